// File: bench/dbr_host_model.sv
// Serial bus master model standing in for the host controller
module dbr_host_model (
  input wire logic         clk_sys,
  input wire logic         miso,
  input wire logic         miso_oe,
  output dbr_pkg::dbr_spi_s spi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial spi = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
  // Half of the 48 ns link clock period
  task automatic half();
    repeat (6) @(negedge clk_sys);
  endtask : half
  task automatic open_frame();
    spi.cs_n = 1'b0;
    half();
  endtask : open_frame
  // Clock stands still outside frames; released data line is garbage
  task automatic close_frame();
    half();
    spi.cs_n = 1'b1;
    spi.mosi = ~spi.mosi;
    repeat (12) @(negedge clk_sys);
  endtask : close_frame
  // MSB first; miso taken as sclk rises, before the device reloads it
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi.mosi = tx[i];
      half();
      // A released line reads inverted so that a gap shows as an error
      rx[i] = miso_oe ? miso : ~miso;
      spi.sclk = 1'b1;
      half();
      spi.sclk = 1'b0;
    end
    half();
    half();
  endtask : shift_byte
endmodule : dbr_host_model

// File: bench/dbr_regmap_props.sv
// Port checker for the dual bank register map
module dbr_regmap_props (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire dbr_pkg::dbr_spi_s spi_in,
  input wire logic              pll_locked,
  input wire logic              low_voltage_trip,
  input wire logic              miso,
  input wire logic              miso_oe,
  input wire logic              bank_a_select,
  input wire logic              strobe_osc_enable,
  input wire logic              pll_unlock_flag,
  input wire logic              low_voltage_latch_alt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles since the detector last tripped, saturating
  logic [3:0] since_trip_reg;
  logic [3:0] since_trip_next;
  always_comb begin
    since_trip_next = since_trip_reg;
    if (low_voltage_trip) since_trip_next = 4'h0;
    else if (since_trip_reg != 4'hf) since_trip_next = since_trip_reg + 4'h1;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) since_trip_reg <= 4'hf;
    else since_trip_reg <= since_trip_next;
  end
  property p_oe_on;
    !spi_in.cs_n [*8] |-> miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("oe low in frame");
  property p_oe_off;
    spi_in.cs_n [*8] |-> !miso_oe && !miso;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso idle");
  // Allows for the input synchroniser delay before the flag follows
  property p_unlock_live;
    $stable(pll_locked) [*8] ##1 $stable(pll_locked) [*4]
      |-> pll_unlock_flag != pll_locked;
  endproperty
  a_unlock_live: assert property (p_unlock_live)
    else $error("unlock");
  property p_latch_set;
    low_voltage_trip [*8] |-> ##1 low_voltage_latch_alt;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch set");
  property p_latch_fall;
    $fell(low_voltage_latch_alt) |-> !spi_in.cs_n;
  endproperty
  a_latch_fall: assert property (p_latch_fall)
    else $error("latch fall");
  property p_latch_rise;
    $rose(low_voltage_latch_alt) |-> since_trip_reg < 4'hc;
  endproperty
  a_latch_rise: assert property (p_latch_rise)
    else $error("latch rise");
  property p_strobe_frame;
    $changed(strobe_osc_enable) |-> !spi_in.cs_n;
  endproperty
  a_strobe_frame: assert property (p_strobe_frame)
    else $error("strobe");
  property p_bank_frame;
    $changed(bank_a_select) |-> !spi_in.cs_n;
  endproperty
  a_bank_frame: assert property (p_bank_frame)
    else $error("bank");
endmodule : dbr_regmap_props

// File: bench/dbr_regmap_tb.sv
// Self-checking bench for the dual bank register map
module dbr_regmap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dbr_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       pll_locked = 1'b1;
  logic       low_voltage_trip = 1'b0;
  logic [7:0] signal_strength_in = 8'h00;
  dbr_spi_s   spi;
  logic       miso, miso_oe, bank_a_select, strobe_osc_enable;
  logic       pll_unlock_flag, low_voltage_latch_alt;
  int         mismatches = 0;
  int         total_checks = 0;
  int         seed = 32'hf16f4157;
  logic [7:0] mem [0:25];
  logic       lv = 1'b1;
  always #2 clk_sys = ~clk_sys;
  dbr_regmap i_dbr_regmap (.clk_sys, .rst_n, .spi_in(spi), .pll_locked,
    .low_voltage_trip, .signal_strength_in, .miso, .miso_oe, .bank_a_select,
    .strobe_osc_enable, .pll_unlock_flag, .low_voltage_latch_alt);
  dbr_host_model i_dbr_host_model (.clk_sys, .miso, .miso_oe, .spi);
  task automatic check(input logic [7:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  function automatic logic [7:0] exp_rd(input int a);
    logic [7:0] v;
    if (a > 25) return 8'h00;
    v = mem[a];
    if (a == 12 || a == 25) v = signal_strength_in;
    if (a == 2 || a == 15) begin
      v[5] = ~pll_locked;
      v[4] = lv;
    end
    if (a == 13) v[3] = 1'b0;
    if (a == 14) v[0] = mem[1][0];
    return v;
  endfunction : exp_rd
  function automatic void model_wr(input int a, input logic [7:0] d);
    if (a == 12 || a >= 25) return;
    if (a == 13) d[3] = mem[13][3];
    if (a == 14) d[0] = mem[14][0];
    mem[a] = d;
  endfunction : model_wr
  task automatic burst(input logic wr, input int a, input int n);
    logic [7:0] rx, d;
    i_dbr_host_model.open_frame();
    i_dbr_host_model.shift_byte({wr, 2'(n - 1), 5'(a)}, rx);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      // Keep clear of the soft reset bit
      if (a == 0) d[3] = 1'b0;
      i_dbr_host_model.shift_byte(wr ? d : 8'h00, rx);
      if (wr) model_wr(a, d);
      else check(rx, exp_rd(a), "read data");
      if (a == 2 || a == 15) lv = 1'b0;
      a = (a == 25 || a == 31) ? 0 : a + 1;
    end
    i_dbr_host_model.close_frame();
  endtask : burst
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #350000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    int a, n;
    logic [7:0] rx;
    for (int i = 0; i < 26; i++) mem[i] = RST_TAB[i];
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (12) @(negedge clk_sys);
    check(8'(bank_a_select), 8'h00, "bank");
    check(8'(strobe_osc_enable), 8'h00, "strobe");
    check(8'(low_voltage_latch_alt), 8'h01, "latch");
    check(8'(pll_unlock_flag), 8'h00, "unlock");
    for (int i = 0; i < 26; i += 4) burst(1'b0, i, 4);
    $display("test reset scan done");
    for (int i = 0; i < 30; i++) begin
      pll_locked = 1'($random(seed));
      signal_strength_in = 8'($random(seed));
      repeat (12) @(negedge clk_sys);
      check(8'(pll_unlock_flag), 8'(!pll_locked), "unlock");
      a = {$random(seed)} % 26;
      n = 1 + {$random(seed)} % 4;
      burst(1'b1, a, n);
      check(8'(strobe_osc_enable), 8'(mem[1][0]), "strobe");
      check(8'(bank_a_select), 8'(mem[9][7]), "bank");
      burst(1'b0, a, n);
    end
    $display("test random bursts done");
    burst(1'b1, 30, 4);
    burst(1'b0, 30, 4);
    // Bytes past the count must leave the next register alone
    i_dbr_host_model.open_frame();
    i_dbr_host_model.shift_byte(8'h85, rx);
    i_dbr_host_model.shift_byte(8'h5a, rx);
    model_wr(5, 8'h5a);
    i_dbr_host_model.shift_byte(8'ha5, rx);
    i_dbr_host_model.close_frame();
    i_dbr_host_model.open_frame();
    i_dbr_host_model.shift_byte(8'h25, rx);
    for (int k = 5; k < 8; k++) begin
      i_dbr_host_model.shift_byte(8'h00, rx);
      check(rx, (k < 7) ? exp_rd(k) : 8'h00, "tail");
    end
    i_dbr_host_model.close_frame();
    $display("test corner cases done");
    for (int j = 0; j < 4; j++) begin
      low_voltage_trip = 1'b1;
      repeat (10) @(negedge clk_sys);
      low_voltage_trip = 1'b0;
      lv = 1'b1;
      repeat (10) @(negedge clk_sys);
      check(8'(low_voltage_latch_alt), 8'h01, "latch set");
      burst(j[1], j[0] ? 2 : 15, 1);
      check(8'(low_voltage_latch_alt), 8'h00, "latch clear");
    end
    $display("test latch done");
    wrap_up();
  end
endmodule : dbr_regmap_tb
bind dbr_regmap dbr_regmap_props i_dbr_regmap_props (.clk_sys, .rst_n,
  .spi_in, .pll_locked, .low_voltage_trip, .miso, .miso_oe, .bank_a_select,
  .strobe_osc_enable, .pll_unlock_flag, .low_voltage_latch_alt);

// File: inc/dbr_pkg.sv
// Shared constants and types of the dual bank register map
package dbr_pkg;

  localparam int          ADDR_W       = 5;
  localparam int          SPACE_BYTES  = 32;
  localparam int          NUM_REGS     = 26;
  localparam logic [4:0]  BANK_B_BASE  = 5'h0d;
  localparam logic [4:0]  LAST_ADDR    = 5'h19;
  localparam logic [4:0]  FIRST_ADDR   = 5'h00;

  // Register offsets
  localparam logic [4:0]  RF_BAND_CONFIG_A       = 5'h00;
  localparam logic [4:0]  MODULATION_CONFIG_A    = 5'h01;
  localparam logic [4:0]  FILTER_STATUS_CONFIG_A = 5'h02;
  localparam logic [4:0]  OPERATION_CONTROL_A    = 5'h03;
  localparam logic [4:0]  RX_ON_OFF_A            = 5'h09;
  localparam logic [4:0]  SIGNAL_STRENGTH_A      = 5'h0c;
  localparam logic [4:0]  RF_BAND_CONFIG_B       = 5'h0d;
  localparam logic [4:0]  MODULATION_CONFIG_B    = 5'h0e;
  localparam logic [4:0]  FILTER_STATUS_CONFIG_B = 5'h0f;
  localparam logic [4:0]  OPERATION_CONTROL_B    = 5'h10;
  localparam logic [4:0]  SIGNAL_STRENGTH_B      = 5'h19;

  // Field positions
  localparam int          RESET_BIT      = 3;
  localparam int          STROBE_EN_BIT  = 0;
  localparam int          PLL_UNLOCK_BIT = 5;
  localparam int          LOW_V_BIT      = 4;
  localparam int          BANK_A_SEL_BIT = 7;

  // Command byte layout
  localparam int          CMD_WRITE_BIT  = 7;
  localparam int          CMD_N_HI       = 6;
  localparam int          CMD_N_LO       = 5;
  localparam logic [2:0]  CMD_N_OFFSET   = 3'h1;
  localparam logic [2:0]  BITS_PER_BYTE  = 3'h7;

  // Reset values, bank A then bank B
  localparam logic [7:0] RST_TAB [0:NUM_REGS-1] = '{
    8'h91, 8'h10, 8'h30, 8'h09, 8'h48, 8'h00, 8'h70, 8'h07, 8'h01,
    8'h7f, 8'hc0, 8'h80, 8'h00,
    8'h91, 8'h10, 8'h30, 8'h09, 8'h48, 8'h00, 8'h70, 8'h07, 8'h01,
    8'h7f, 8'hc0, 8'h80, 8'h00
  };

  localparam logic        PLL_UNLOCK_RST = 1'b1;
  localparam logic        LOW_V_RST      = 1'b1;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } dbr_spi_s;

  typedef enum logic [1:0] {
    DBR_IDLE = 2'b00,
    DBR_CMD  = 2'b01,
    DBR_DATA = 2'b10,
    DBR_DONE = 2'b11
  } dbr_state_e;

endpackage : dbr_pkg

// File: verilog/dbr_regmap.sv
// Dual bank register map behind the serial configuration port
module dbr_regmap (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire dbr_pkg::dbr_spi_s spi_in,
  input  wire logic           pll_locked,
  input  wire logic           low_voltage_trip,
  input  wire logic [7:0]     signal_strength_in,
  output logic                miso,
  output logic                miso_oe,
  output logic                bank_a_select,
  output logic                strobe_osc_enable,
  output logic                pll_unlock_flag,
  output logic                low_voltage_latch_alt
);
  import dbr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [4:0] raw_in;
  logic [4:0] syn;
  logic       cs_n_s;
  logic       sclk_s;
  logic       mosi_s;
  logic       locked_s;
  logic       trip_s;

  assign raw_in = {spi_in.cs_n, spi_in.sclk, spi_in.mosi,
                   pll_locked, low_voltage_trip};

  dbr_sync #(
    .WIDTH (5),
    .INIT  (5'h10)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (raw_in),
    .sync_out (syn)
  );

  assign cs_n_s   = syn[4];
  assign sclk_s   = syn[3];
  assign mosi_s   = syn[2];
  assign locked_s = syn[1];
  assign trip_s   = syn[0];

  ////////////////////////////////////////////////////////////////////////////
  // Access helpers

  function automatic logic [7:0] wr_mask(input logic [4:0] a);
    logic [7:0] m;
    m = 8'hff;
    if (a > LAST_ADDR) m = 8'h00;
    unique case (a)
      RF_BAND_CONFIG_B:       m = ~(8'h01 << RESET_BIT);
      FILTER_STATUS_CONFIG_A,
      FILTER_STATUS_CONFIG_B: m = ~((8'h01 << PLL_UNLOCK_BIT) |
                                    (8'h01 << LOW_V_BIT));
      MODULATION_CONFIG_B:    m = ~(8'h01 << STROBE_EN_BIT);
      SIGNAL_STRENGTH_A,
      SIGNAL_STRENGTH_B:      m = 8'h00;
      default:                m = m;
    endcase
    return m;
  endfunction : wr_mask

  function automatic logic [4:0] addr_inc(input logic [4:0] a);
    return (a == LAST_ADDR) ? FIRST_ADDR : 5'(a + 5'h01);
  endfunction : addr_inc

  ////////////////////////////////////////////////////////////////////////////
  // State

  dbr_state_e state_reg, state_next;
  logic [7:0] mem_reg  [0:NUM_REGS-1];
  logic [7:0] mem_next [0:NUM_REGS-1];
  logic [4:0] addr_reg, addr_next;
  logic [2:0] left_reg, left_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shin_reg, shin_next;
  logic [7:0] shout_reg, shout_next;
  logic       write_reg, write_next;
  logic       sclk_d_reg;
  logic       lowv_reg, lowv_next;
  logic       unlock_reg;
  logic       miso_reg, miso_next;
  logic       oe_reg;
  logic       bank_reg;
  logic       soe_reg;

  logic       rise;
  logic       fall;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic       rd_access;
  logic       wr_access;
  logic [4:0] rd_addr;

  assign rise    = sclk_s & ~sclk_d_reg & ~cs_n_s;
  assign fall    = ~sclk_s & sclk_d_reg & ~cs_n_s;
  assign byte_in = {shin_reg[6:0], mosi_s};

  // Read value of any register, whichever bank is active
  always_comb begin
    rd_addr = (state_reg == DBR_CMD) ? byte_in[4:0] : addr_inc(addr_reg);
    rd_byte = 8'h00;
    if (rd_addr <= LAST_ADDR) begin
      rd_byte = mem_reg[rd_addr];
    end
    unique case (rd_addr)
      RF_BAND_CONFIG_B: rd_byte[RESET_BIT] = 1'b0;
      FILTER_STATUS_CONFIG_A, FILTER_STATUS_CONFIG_B: begin
        rd_byte[PLL_UNLOCK_BIT] = unlock_reg;
        rd_byte[LOW_V_BIT]      = lowv_reg;
      end
      MODULATION_CONFIG_B:
        rd_byte[STROBE_EN_BIT] =
          mem_reg[MODULATION_CONFIG_A][STROBE_EN_BIT];
      SIGNAL_STRENGTH_A, SIGNAL_STRENGTH_B:
        rd_byte = signal_strength_in;
      default: rd_byte = rd_byte;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    left_next  = left_reg;
    bit_next   = bit_reg;
    shin_next  = shin_reg;
    shout_next = shout_reg;
    write_next = write_reg;
    miso_next  = miso_reg;
    rd_access  = 1'b0;
    wr_access  = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (cs_n_s) begin
      // Frame end aborts any partial byte
      state_next = DBR_IDLE;
      bit_next   = 3'h0;
      miso_next  = 1'b0;
    end else begin
      if (state_reg == DBR_IDLE) begin
        state_next = DBR_CMD;
      end
      if (rise) begin
        shin_next = byte_in;
        bit_next  = 3'(bit_reg + 3'h1);
        if (bit_reg == BITS_PER_BYTE) begin
          bit_next = 3'h0;
          unique case (state_reg)
            DBR_IDLE, DBR_CMD: begin
              addr_next  = byte_in[4:0];
              left_next  = 3'({1'b0, byte_in[CMD_N_HI:CMD_N_LO]} +
                              CMD_N_OFFSET);
              write_next = byte_in[CMD_WRITE_BIT];
              state_next = DBR_DATA;
              if (!byte_in[CMD_WRITE_BIT]) begin
                rd_access  = 1'b1;
                shout_next = rd_byte;
                miso_next  = rd_byte[7];
              end
            end
            DBR_DATA: begin
              left_next = 3'(left_reg - 3'h1);
              if (write_reg) begin
                wr_access = 1'b1;
                if (addr_reg <= LAST_ADDR) begin
                  mem_next[addr_reg] = (mem_reg[addr_reg] &
                                        ~wr_mask(addr_reg)) |
                                       (byte_in & wr_mask(addr_reg));
                end
              end
              if (left_reg == 3'h1) begin
                state_next = DBR_DONE;
                miso_next  = 1'b0;
              end else begin
                addr_next = addr_inc(addr_reg);
                if (!write_reg) begin
                  rd_access  = 1'b1;
                  shout_next = rd_byte;
                  miso_next  = rd_byte[7];
                end
              end
            end
            DBR_DONE: state_next = DBR_DONE;
          endcase
        end
      end
      if (fall && bit_reg != 3'h0 && state_reg == DBR_DATA && !write_reg) begin
        shout_next = {shout_reg[6:0], 1'b0};
        miso_next  = shout_reg[6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  logic lv_hit;
  always_comb begin
    // Access of either bank's status byte clears the latch
    lv_hit = (rd_access && (rd_addr == FILTER_STATUS_CONFIG_A ||
                            rd_addr == FILTER_STATUS_CONFIG_B)) ||
             (wr_access && (addr_reg == FILTER_STATUS_CONFIG_A ||
                            addr_reg == FILTER_STATUS_CONFIG_B));
    lowv_next = lowv_reg;
    if (lv_hit) lowv_next = 1'b0;
    // A trip in the clearing cycle is not lost
    if (trip_s) lowv_next = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg  <= DBR_IDLE;
      mem_reg    <= RST_TAB;
      addr_reg   <= FIRST_ADDR;
      left_reg   <= 3'h0;
      bit_reg    <= 3'h0;
      shin_reg   <= 8'h00;
      shout_reg  <= 8'h00;
      write_reg  <= 1'b0;
      sclk_d_reg <= 1'b0;
      lowv_reg   <= LOW_V_RST;
      unlock_reg <= PLL_UNLOCK_RST;
      miso_reg   <= 1'b0;
      oe_reg     <= 1'b0;
      bank_reg   <= RST_TAB[RX_ON_OFF_A][BANK_A_SEL_BIT];
      soe_reg    <= RST_TAB[MODULATION_CONFIG_A][STROBE_EN_BIT];
    end else begin
      state_reg  <= state_next;
      mem_reg    <= mem_next;
      addr_reg   <= addr_next;
      left_reg   <= left_next;
      bit_reg    <= bit_next;
      shin_reg   <= shin_next;
      shout_reg  <= shout_next;
      write_reg  <= write_next;
      sclk_d_reg <= sclk_s;
      lowv_reg   <= lowv_next;
      unlock_reg <= ~locked_s;
      miso_reg   <= miso_next;
      oe_reg     <= ~cs_n_s;
      bank_reg   <= mem_next[RX_ON_OFF_A][BANK_A_SEL_BIT];
      soe_reg    <= mem_next[MODULATION_CONFIG_A][STROBE_EN_BIT];
    end
  end

  assign miso                  = miso_reg;
  assign miso_oe               = oe_reg;
  assign bank_a_select         = bank_reg;
  assign strobe_osc_enable     = soe_reg;
  assign pll_unlock_flag       = unlock_reg;
  assign low_voltage_latch_alt = lowv_reg;

endmodule : dbr_regmap

// File: verilog/dbr_sync.sv
// Three stage input synchroniser with agreement filter
module dbr_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // A change counts only once stages two and three agree
      always_comb begin
        out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : out_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_reg  <= INIT;
      s2_reg  <= INIT;
      s3_reg  <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule : dbr_sync
